// ### core/dual_console_port_mode_control.sv
/*
  Mode control, echo, boot command detection and strapping for two console ports.
  Port 0 is the master, port 1 the slave. Assumes external UARTs with a ready/valid transmit side,
  a panel command decoder giving run and slave on/off pulses, and panel text offered as a stream.
*/
module dual_console_port_mode_control
  import console_pkg::*;
(
  input wire logic clk_sys, // System clock, 25 MHz
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [1:0] rxValid, // UART received character strobe
  input wire logic [1:0][7:0] rxData, // UART received character
  input wire logic [1:0] txReady, // UART can take a character
  output logic [1:0] txValid_reg, // Character offered to UART
  output logic [1:0][7:0] txData_reg, // Character to UART
  input wire logic [1:0][BAUD_W-1:0] baudJumper, // Baud jumpers per port
  output logic [1:0][BAUD_W-1:0] baudCfg_reg, // Baud setting to UART
  output logic baudLoad_reg, // Load baud setting
  input wire logic variantStrap, // High on the reduced console variant
  input wire logic cpuRun, // Host processor in run state
  input wire logic runCmd, // Run command decoded at the panel
  input wire logic slaveOff, // Panel command: slave port off
  input wire logic slaveOn, // Panel command: slave port on
  input wire logic panelOutValid, // Panel text character offered
  input wire logic [7:0] panelOutData, // Panel text character
  output logic panelOutTaken_reg, // Panel character accepted
  output logic panelRefresh_reg, // Ask panel to send current data
  input wire logic [1:0] swTxValid, // Software character to send
  input wire logic [1:0][7:0] swTxData, // Software character
  output logic [1:0] swTxTaken_reg, // Software character accepted
  output logic [1:0] swRxValid_reg, // Character to software
  output logic [1:0][7:0] swRxData_reg, // Character to software
  output logic [1:0] attn_reg, // Operator attention per port
  output logic [1:0] rxBad_reg, // Character with top bit set dropped
  output logic consoleMode_reg, // Console mode active
  output logic slaveEn_reg, // Slave acts as second panel
  output logic bootReq_reg, // Boot load request to host
  output logic [15:0] bootAddr_reg, // Boot device address
  input wire logic ioClassValid, // I/O class code present
  input wire logic [3:0] ioClassIn, // I/O class code
  output logic classHit_reg, // Class code recognised
  output logic [3:0] classStd_reg, // Class code in standard form
  output logic [7:0] panelAddr_reg, // Physical address of panel function
  output logic [7:0] rtomAddr_reg // Physical address of realtime option function
);

  mode_e mode_reg, mode_next;
  echo_e echo_reg, echo_next;
  boot_e boot_reg, boot_next;
  logic runPrev_reg, strapPend_reg, variant_reg, variant_next;
  logic [1:0] holdValid, chOk, take, echoLoad, escPanel, escAttn;
  logic [1:0][7:0] holdData;
  logic [7:0] echoChar_reg, echoChar_next;
  logic echoRx_reg, echoRx_next, olderSlave_reg, olderSlave_next;
  logic [1:0] hexCnt_reg, hexCnt_next;
  logic [15:0] bootAddr_next;
  logic bootReq_next, panelOutTaken_next, panelRefresh_next, consoleMode_next, slaveEn_next;
  logic baudLoad_next, classHit_next;
  logic [1:0][BAUD_W-1:0] baudCfg_next;
  logic [3:0] classStd_next;
  logic [7:0] panelAddr_next, rtomAddr_next;
  logic feed, fire;
  logic [4:0] hexDig;

  function automatic logic [4:0] hexVal(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) begin
      hexVal = {1'b1, c[3:0]};
    end else if (c >= 8'h41 && c <= 8'h46) begin
      hexVal = {1'b1, c[3:0] + 4'h9};
    end else begin
      hexVal = 5'h00;
    end
  endfunction : hexVal

  // ----------------------------------------------------------------
  // Mode, straps, class mapping
  // ----------------------------------------------------------------
  always_comb begin
    mode_next = mode_reg;
    slaveEn_next = slaveEn_reg;
    panelRefresh_next = 1'b0;
    if (mode_reg == MODE_PANEL && (runCmd || (cpuRun && !runPrev_reg))) begin
      mode_next = MODE_CONSOLE;
    end else if (mode_reg == MODE_CONSOLE && !cpuRun && runPrev_reg) begin
      mode_next = MODE_PANEL;
      panelRefresh_next = 1'b1;
    end else if (mode_reg == MODE_CONSOLE && (escPanel[0] || (escPanel[1] && slaveEn_reg))) begin
      mode_next = MODE_PANEL;
      panelRefresh_next = 1'b1;
    end
    if (slaveOff) begin
      slaveEn_next = 1'b0;
    end else if (slaveOn) begin
      slaveEn_next = 1'b1;
    end
    consoleMode_next = (mode_next == MODE_CONSOLE);
    variant_next = strapPend_reg ? variantStrap : variant_reg;
    baudLoad_next = strapPend_reg;
    baudCfg_next = strapPend_reg ? baudJumper : baudCfg_reg;
    panelAddr_next = variant_next ? ADDR_PANEL_RED : ADDR_PANEL_STD;
    rtomAddr_next = variant_next ? ADDR_REALTIME_OPTION_FUNCTION_RED : ADDR_REALTIME_OPTION_FUNCTION_STD;
    classHit_next = 1'b0;
    classStd_next = 4'h0;
    if (ioClassValid && variant_reg) begin
      classHit_next = 1'b1;
      unique case (ioClassIn)
        CLS_RED_7: classStd_next = CLS_STD_F;
        CLS_RED_B: classStd_next = CLS_STD_3;
        CLS_RED_6: classStd_next = CLS_STD_E;
        default: classHit_next = 1'b0;
      endcase
    end else if (ioClassValid) begin
      classHit_next = (ioClassIn == CLS_STD_F) || (ioClassIn == CLS_STD_3) || (ioClassIn == CLS_STD_E);
      classStd_next = classHit_next ? ioClassIn : 4'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mode_reg <= MODE_PANEL;
      slaveEn_reg <= SLAVE_EN_RESET;
      consoleMode_reg <= 1'b0;
      panelRefresh_reg <= 1'b0;
      runPrev_reg <= 1'b0;
      strapPend_reg <= 1'b1;
      variant_reg <= 1'b0;
      baudLoad_reg <= 1'b0;
      baudCfg_reg <= '0;
      panelAddr_reg <= ADDR_PANEL_STD;
      rtomAddr_reg <= ADDR_REALTIME_OPTION_FUNCTION_STD;
      classHit_reg <= 1'b0;
      classStd_reg <= 4'h0;
    end else begin
      mode_reg <= mode_next;
      slaveEn_reg <= slaveEn_next;
      consoleMode_reg <= consoleMode_next;
      panelRefresh_reg <= panelRefresh_next;
      runPrev_reg <= cpuRun;
      strapPend_reg <= 1'b0;
      variant_reg <= variant_next;
      baudLoad_reg <= baudLoad_next;
      baudCfg_reg <= baudCfg_next;
      panelAddr_reg <= panelAddr_next;
      rtomAddr_reg <= rtomAddr_next;
      classHit_reg <= classHit_next;
      classStd_reg <= classStd_next;
    end
  end

  // ----------------------------------------------------------------
  // Echo path and boot command detection
  // ----------------------------------------------------------------
  always_comb begin
    echo_next = echo_reg;
    echoChar_next = echoChar_reg;
    echoRx_next = echoRx_reg;
    olderSlave_next = olderSlave_reg;
    take = 2'b00;
    panelOutTaken_next = 1'b0;
    echoLoad[0] = (echo_reg == ECHO_MASTER) && !txValid_reg[0];
    echoLoad[1] = (echo_reg == ECHO_SLAVE) && !txValid_reg[1];
    if (!holdValid[0] && holdValid[1]) begin
      olderSlave_next = 1'b1;
    end else if (!holdValid[1]) begin
      olderSlave_next = 1'b0;
    end
    unique case (echo_reg)
      ECHO_IDLE: begin
        if (mode_reg == MODE_PANEL) begin
          if (holdValid[0] && !(holdValid[1] && olderSlave_reg)) begin
            take[0] = 1'b1;
          end else if (holdValid[1]) begin
            take[1] = 1'b1;
          end else if (panelOutValid) begin
            panelOutTaken_next = 1'b1;
          end
        end
        if (take != 2'b00 || panelOutTaken_next) begin
          echoChar_next = take[1] ? holdData[1] : (take[0] ? holdData[0] : panelOutData);
          echoChar_next[CH_MSB] = 1'b0;
          echoRx_next = (take != 2'b00);
          echo_next = ECHO_MASTER;
        end
      end
      ECHO_MASTER: begin
        if (echoLoad[0]) begin
          echo_next = slaveEn_reg ? ECHO_SLAVE : ECHO_IDLE;
        end
      end
      ECHO_SLAVE: begin
        if (echoLoad[1]) begin
          echo_next = ECHO_IDLE;
        end
      end
      default: echo_next = ECHO_IDLE;
    endcase
  end

  always_comb begin
    boot_next = boot_reg;
    hexCnt_next = hexCnt_reg;
    bootAddr_next = bootAddr_reg;
    bootReq_next = 1'b0;
    fire = 1'b0;
    hexDig = hexVal(echoChar_reg);
    feed = (echo_reg == ECHO_MASTER) && echoLoad[0] && echoRx_reg;
    if (feed) begin
      if (echoChar_reg == CH_CR) begin
        if (boot_reg == BOOT_OPT) begin
          bootAddr_next = BOOT_DEFAULT_ADDR;
          fire = 1'b1;
        end else if (boot_reg == BOOT_CR) begin
          fire = 1'b1;
        end
        boot_next = BOOT_I;
      end else begin
        unique case (boot_reg)
          BOOT_I: boot_next = (echoChar_reg == CH_I) ? BOOT_P : BOOT_SKIP;
          BOOT_P: boot_next = (echoChar_reg == CH_P) ? BOOT_L : BOOT_SKIP;
          BOOT_L: boot_next = (echoChar_reg == CH_L) ? BOOT_OPT : BOOT_SKIP;
          BOOT_OPT: begin
            boot_next = (echoChar_reg == CH_EQ) ? BOOT_HEX : BOOT_SKIP;
            hexCnt_next = 2'h0;
          end
          BOOT_HEX: begin
            if (hexDig[4]) begin
              bootAddr_next = {bootAddr_reg[11:0], hexDig[3:0]};
              hexCnt_next = hexCnt_reg + 2'h1;
              boot_next = (hexCnt_reg == 2'(HEX_DIGITS - 1)) ? BOOT_CR : BOOT_HEX;
            end else begin
              boot_next = BOOT_SKIP;
            end
          end
          BOOT_CR, BOOT_SKIP: boot_next = BOOT_SKIP;
          default: boot_next = BOOT_SKIP;
        endcase
      end
    end
    // Only the host notification is extra; the transfer itself is an ordinary read
    bootReq_next = fire && !variant_reg;
    if (variant_reg) begin
      bootAddr_next = bootAddr_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      echo_reg <= ECHO_IDLE;
      echoChar_reg <= 8'h00;
      echoRx_reg <= 1'b0;
      olderSlave_reg <= 1'b0;
      panelOutTaken_reg <= 1'b0;
      boot_reg <= BOOT_I;
      hexCnt_reg <= 2'h0;
      bootAddr_reg <= 16'h0000;
      bootReq_reg <= 1'b0;
    end else begin
      echo_reg <= echo_next;
      echoChar_reg <= echoChar_next;
      echoRx_reg <= echoRx_next;
      olderSlave_reg <= olderSlave_next;
      panelOutTaken_reg <= panelOutTaken_next;
      boot_reg <= boot_next;
      hexCnt_reg <= hexCnt_next;
      bootAddr_reg <= bootAddr_next;
      bootReq_reg <= bootReq_next;
    end
  end

  // ----------------------------------------------------------------
  // Per-port receive and transmit
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_port
    logic holdV_reg, holdV_next, txV_reg, txV_next, taken_reg, taken_next;
    logic rxV_reg, rxV_next, bad_reg, bad_next, portOn;
    logic [7:0] holdD_reg, holdD_next, txD_reg, txD_next, rxD_reg, rxD_next;

    assign portOn = (i == 0) || slaveEn_reg;
    assign chOk[i] = rxValid[i] && !rxData[i][CH_MSB];

    esc_seq_scan u_scan (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .enable(mode_reg == MODE_CONSOLE && portOn),
      .chValid(chOk[i]),
      .chData(rxData[i]),
      .hitPanel_reg(escPanel[i]),
      .hitAttn_reg(escAttn[i])
    );

    always_comb begin
      bad_next = rxValid[i] && rxData[i][CH_MSB];
      holdV_next = holdV_reg && !take[i];
      holdD_next = holdD_reg;
      if (chOk[i] && mode_reg == MODE_PANEL && portOn && !holdV_next) begin
        holdV_next = 1'b1;
        holdD_next = rxData[i];
      end
      rxV_next = chOk[i] && mode_reg == MODE_CONSOLE;
      rxD_next = rxV_next ? rxData[i] : rxD_reg;
      txV_next = txV_reg && !txReady[i];
      txD_next = txD_reg;
      taken_next = 1'b0;
      if (echoLoad[i]) begin
        txV_next = 1'b1;
        txD_next = echoChar_reg;
      end else if (mode_reg == MODE_CONSOLE && echo_reg == ECHO_IDLE && swTxValid[i] && !txV_reg && !taken_reg) begin
        txV_next = 1'b1;
        txD_next = {1'b0, swTxData[i][6:0]};
        taken_next = 1'b1;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!resetn) begin
        holdV_reg <= 1'b0;
        holdD_reg <= 8'h00;
        rxV_reg <= 1'b0;
        rxD_reg <= 8'h00;
        txV_reg <= 1'b0;
        txD_reg <= 8'h00;
        taken_reg <= 1'b0;
        bad_reg <= 1'b0;
      end else begin
        holdV_reg <= holdV_next;
        holdD_reg <= holdD_next;
        rxV_reg <= rxV_next;
        rxD_reg <= rxD_next;
        txV_reg <= txV_next;
        txD_reg <= txD_next;
        taken_reg <= taken_next;
        bad_reg <= bad_next;
      end
    end

    assign holdValid[i] = holdV_reg;
    assign holdData[i] = holdD_reg;
    assign txValid_reg[i] = txV_reg;
    assign txData_reg[i] = txD_reg;
    assign swTxTaken_reg[i] = taken_reg;
    assign swRxValid_reg[i] = rxV_reg;
    assign swRxData_reg[i] = rxD_reg;
    assign rxBad_reg[i] = bad_reg;
    assign attn_reg[i] = escAttn[i];
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_mode_exclusive: assert property (consoleMode_reg == (mode_reg == MODE_CONSOLE))
    else $error("mode flag disagrees with mode state");
  a_run_enters_console: assert property (mode_reg == MODE_PANEL && runCmd |=> mode_reg == MODE_CONSOLE)
    else $error("run did not enter console mode");
  a_halt_to_panel: assert property (mode_reg == MODE_CONSOLE && $fell(cpuRun) |-> ##1 (mode_reg == MODE_PANEL && panelRefresh_reg))
    else $error("halt did not restore panel mode");
  a_slave_copy: assert property (echo_reg == ECHO_MASTER && echoLoad[0] && slaveEn_reg |=> echo_reg == ECHO_SLAVE ##[0:1000] echoLoad[1])
    else $error("slave did not get the echoed character");
  a_echo_data: assert property (echoLoad[0] |=> txValid_reg[0] && txData_reg[0] == $past(echoChar_reg))
    else $error("echoed character wrong on master");
  a_console_pass: assert property (mode_reg == MODE_CONSOLE && chOk[1] |=> swRxValid_reg[1] && swRxData_reg[1] == $past(rxData[1]))
    else $error("console character not passed on");
  a_baud_sample: assert property ($rose(resetn) |-> ##1 (baudLoad_reg && baudCfg_reg == $past(baudJumper)))
    else $error("baud jumpers not loaded after reset");
  a_msb_clear: assert property (txValid_reg[0] |-> !txData_reg[0][CH_MSB])
    else $error("transmitted character has top bit set");
  a_boot_variant: assert property (bootReq_reg |-> !variant_reg)
    else $error("boot request on reduced variant");
  a_class_map: assert property (ioClassValid && variant_reg && ioClassIn == CLS_RED_B |=> classHit_reg && classStd_reg == CLS_STD_3)
    else $error("reduced class code not mapped");

  c_boot_request: cover property (bootReq_reg);
  c_slave_echo: cover property (echoLoad[1] && echoRx_reg);
  c_escape_return: cover property (escPanel[0] && mode_reg == MODE_CONSOLE);

endmodule : dual_console_port_mode_control

// ### core/console_pkg.sv
/*
  Shared constants and types for the dual console port mode control.
  Assumes one 25 MHz clock, synchronous active-low reset, external UARTs and an external panel command decoder.
*/
// Behaviour
// - Exactly one of panel mode or console mode is active at any time.
// - Run command or processor entering run switches panel mode to console mode.
// - Processor run-to-halt returns to panel mode and requests a display refresh.
// - After reset panel output reaches both terminals unless the slave was deactivated.
// - With the slave active, master and slave get identical panel output.
// - In panel mode each received character is stored, then echoed on the master and, with the slave active, on the slave.
// - Simultaneous typing is merged into one command in arrival order.
// - Console mode runs both ports independently under software, no echo.
// - Four baud jumpers per port are sampled at reset and loaded into the UART.
// - Panel output is written to each port in turn, paced by the slower.
// - Console mode lets each port transmit at its own rate.
// - Characters are eight bits with the top bit zero; others are incomplete.
// - Accept boot default and boot addressed commands, both ending in carriage return.
// - Either boot command notifies the host processor to start its boot load.
// - A boot transfer is an ordinary read apart from the host notification.
// - The reduced variant omits boot load and clock override.
// - The reduced variant maps I/O classes 7, B, 6 onto F, 3, E.
// - Realtime option answers at 7F or 73, panel function at 7E or 72.
// - At power-up both ports start in panel mode with the slave enabled.
// - Console mode scans input for the return-to-panel and attention sequences.
package console_pkg;

  // ----------------------------------------------------------------
  // Character codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_AT = 8'h40;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_I = 8'h49;
  localparam logic [7:0] CH_L = 8'h4C;
  localparam logic [7:0] CH_EQ = 8'h3D;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam int CH_MSB = 7;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int BAUD_W = 4;
  localparam int HEX_DIGITS = 4;
  localparam logic SLAVE_EN_RESET = 1'b1;
  // Arbitrary neutral value; the real default boot device address is set elsewhere
  localparam logic [15:0] BOOT_DEFAULT_ADDR = 16'h0000;

  // ----------------------------------------------------------------
  // I/O classes and physical addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] CLS_STD_F = 4'hF;
  localparam logic [3:0] CLS_STD_3 = 4'h3;
  localparam logic [3:0] CLS_STD_E = 4'hE;
  localparam logic [3:0] CLS_RED_7 = 4'h7;
  localparam logic [3:0] CLS_RED_B = 4'hB;
  localparam logic [3:0] CLS_RED_6 = 4'h6;
  localparam logic [7:0] ADDR_REALTIME_OPTION_FUNCTION_STD = 8'h7F;
  localparam logic [7:0] ADDR_REALTIME_OPTION_FUNCTION_RED = 8'h73;
  localparam logic [7:0] ADDR_PANEL_STD = 8'h7E;
  localparam logic [7:0] ADDR_PANEL_RED = 8'h72;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic {MODE_PANEL, MODE_CONSOLE} mode_e;
  typedef enum logic [1:0] {ECHO_IDLE, ECHO_MASTER, ECHO_SLAVE} echo_e;
  typedef enum logic [2:0] {BOOT_I, BOOT_P, BOOT_L, BOOT_OPT, BOOT_HEX, BOOT_CR, BOOT_SKIP} boot_e;

endpackage : console_pkg

// ### core/esc_seq_scan.sv
/*
  Escape sequence scanner for one console port.
  Assumes one character per valid pulse, already checked for a clear top bit.
*/
module esc_seq_scan
  import console_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic enable, // Scanning allowed
  input wire logic chValid, // Character strobe
  input wire logic [7:0] chData, // Character code
  output logic hitPanel_reg, // Return-to-panel sequence seen
  output logic hitAttn_reg // Attention sequence seen
);

  logic [1:0] atCnt_reg;
  logic [1:0] atCnt_next;
  logic hitPanel_next;
  logic hitAttn_next;

  // ----------------------------------------------------------------
  // Two at-signs followed by a letter
  // ----------------------------------------------------------------
  always_comb begin
    atCnt_next = atCnt_reg;
    hitPanel_next = 1'b0;
    hitAttn_next = 1'b0;
    if (!enable) begin
      atCnt_next = 2'h0;
    end else if (chValid) begin
      if (chData == CH_AT) begin
        atCnt_next = (atCnt_reg == 2'h2) ? 2'h2 : atCnt_reg + 2'h1;
      end else begin
        atCnt_next = 2'h0;
        hitPanel_next = (atCnt_reg == 2'h2) && (chData == CH_P);
        hitAttn_next = (atCnt_reg == 2'h2) && (chData == CH_A);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      atCnt_reg <= 2'h0;
      hitPanel_reg <= 1'b0;
      hitAttn_reg <= 1'b0;
    end else begin
      atCnt_reg <= atCnt_next;
      hitPanel_reg <= hitPanel_next;
      hitAttn_reg <= hitAttn_next;
    end
  end

  a_escape_panel: assert property (@(posedge clk_sys) disable iff (!resetn)
    enable && chValid && chData == CH_P && atCnt_reg == 2'h2 |=> hitPanel_reg)
    else $error("panel escape not reported");

endmodule : esc_seq_scan

// ### verif/term_model.sv
/*
  Terminal on the transmit side of one console UART.
  Assumes the design holds txValid and txData until txReady is seen.
*/
module term_model (
  input wire logic clk_sys, // System clock
  input wire logic txValid, // Character offered
  input wire logic [7:0] txData, // Character
  output logic txReady, // Terminal takes character
  output logic gotCh, // Character taken at last edge
  output logic [7:0] lastCh // Last character taken
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ready comes and goes so either port may be the slower one
  always @(posedge clk_sys) begin
    txReady <= ($urandom % 3) != 0;
    gotCh <= txValid && txReady;
    if (txValid && txReady) lastCh <= txData;
  end
endmodule : term_model

// ### verif/testbench.sv
/*
  Self-checking bench for the dual console port mode control.
  Assumes a terminal model on each transmit path.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import console_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, variantStrap = 1'b0, cpuRun = 1'b0, runCmd = 1'b0;
  logic slaveOff = 1'b0, slaveOn = 1'b0, ioClassValid = 1'b0, panelOutValid = 1'b0;
  logic baudLoad, panelOutTaken, panelRefresh, consoleMode, slaveEn, bootReq, classHit;
  logic [1:0] rxValid = 2'h0, swTxValid = 2'h0, txReady, txValid, swTxTaken, swRxValid, attn, rxBad, got;
  logic [1:0][7:0] rxData = '0, swTxData = '0, txData, swRxData, lastCh;
  logic [1:0][3:0] baudJumper = {4'hA, 4'h5}, baudCfg;
  logic [7:0] panelOutData = 8'h00, panelAddr, rtomAddr, swSeen = 8'h00;
  logic [3:0] ioClassIn = 4'h0, classStd;
  logic [15:0] bootAddr, bootSeenAddr = 16'hFFFF;
  logic [1:0] badSeen = 2'h0, attnSeen = 2'h0;
  int failures = 0, checks = 0, cyc = 0, bootCnt = 0, expBoot = 0, refCnt = 0;
  always #20 clk_sys = ~clk_sys;
  dual_console_port_mode_control dual_console_port_mode_control_i (.clk_sys(clk_sys), .resetn(resetn),
    .rxValid(rxValid), .rxData(rxData), .txReady(txReady), .txValid_reg(txValid), .txData_reg(txData),
    .baudJumper(baudJumper), .baudCfg_reg(baudCfg), .baudLoad_reg(baudLoad), .variantStrap(variantStrap),
    .cpuRun(cpuRun), .runCmd(runCmd), .slaveOff(slaveOff), .slaveOn(slaveOn), .panelOutValid(panelOutValid),
    .panelOutData(panelOutData), .panelOutTaken_reg(panelOutTaken), .panelRefresh_reg(panelRefresh),
    .swTxValid(swTxValid), .swTxData(swTxData), .swTxTaken_reg(swTxTaken), .swRxValid_reg(swRxValid),
    .swRxData_reg(swRxData), .attn_reg(attn), .rxBad_reg(rxBad), .consoleMode_reg(consoleMode),
    .slaveEn_reg(slaveEn), .bootReq_reg(bootReq), .bootAddr_reg(bootAddr), .ioClassValid(ioClassValid),
    .ioClassIn(ioClassIn), .classHit_reg(classHit), .classStd_reg(classStd), .panelAddr_reg(panelAddr),
    .rtomAddr_reg(rtomAddr));
  term_model term_model_i[1:0] (.clk_sys(clk_sys), .txValid(txValid), .txData(txData), .txReady(txReady),
    .gotCh(got), .lastCh(lastCh));
  // Sticky records of output pulses, and the hang limit
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    // Host side only records the request; it builds its own chained read itself
    if (bootReq) begin
      bootCnt <= bootCnt + 1;
      bootSeenAddr <= bootAddr;
    end
    if (swRxValid[1]) swSeen <= swRxData[1];
    badSeen <= badSeen | rxBad;
    attnSeen <= attnSeen | attn;
    if (panelRefresh) refCnt <= refCnt + 1;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc_n
  task automatic rx(input int p, input logic [7:0] ch);
    rxValid[p] <= 1'b1;
    rxData[p] <= ch;
    cyc_n(1);
    rxValid[p] <= 1'b0;
    cyc_n(1);
  endtask : rx
  task automatic both(input logic [7:0] ch);
    logic [1:0] seen;
    seen = 2'b00;
    repeat (60) begin
      seen = seen | got;
      if (seen == 2'b11) break;
      cyc_n(1);
    end
    chk(seen, 16'h0003);
    for (int q = 0; q < 2; q++) chk(lastCh[q], ch);
    cyc_n(1);
  endtask : both
  task automatic echo(input int p, input logic [7:0] ch);
    rx(p, ch);
    both(ch);
  endtask : echo
  task automatic boot(input logic [79:0] c, input int n, input int en, input logic [15:0] a);
    for (int i = n - 1; i >= 0; i--) echo(i % 2, c[8*i+:8]);
    cyc_n(3);
    expBoot += en;
    chk(16'(bootCnt), 16'(expBoot));
    if (en != 0) chk(bootSeenAddr, a);
  endtask : boot
  task automatic cls(input logic [3:0] c, input logic hit, input logic [3:0] s);
    ioClassValid <= 1'b1;
    ioClassIn <= c;
    cyc_n(1);
    ioClassValid <= 1'b0;
    cyc_n(1);
    chk(classHit, hit);
    if (hit) chk(classStd, s);
  endtask : cls
  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h8A991135));
    cyc_n(5);
    resetn <= 1'b1;
    cyc_n(3);
    chk({consoleMode, slaveEn}, 16'h0001);
    chk({panelAddr, rtomAddr}, 16'h7E7F);
    chk(baudCfg, 16'h00A5);
    cls(4'hF, 1'b1, 4'hF);
    cls(4'h7, 1'b0, 4'h0);
    for (int i = 0; i < 6; i++) echo(i % 2, 8'($urandom) & 8'h7F);
    panelOutValid <= 1'b1;
    panelOutData <= 8'h4B;
    repeat (10) begin
      cyc_n(1);
      if (panelOutTaken) break;
    end
    panelOutValid <= 1'b0;
    chk(panelOutTaken, 16'h0001);
    both(8'h4B);
    rx(0, 8'hC1);
    cyc_n(2);
    chk(badSeen, 16'h0001);
    boot("\rIPL\r", 5, 1, BOOT_DEFAULT_ADDR);
    boot("\rIPL=12AB\r", 10, 1, 16'h12AB);
    slaveOff <= 1'b1;
    cyc_n(1);
    slaveOff <= 1'b0;
    cyc_n(2);
    chk(slaveEn, 16'h0000);
    slaveOn <= 1'b1;
    cyc_n(1);
    slaveOn <= 1'b0;
    cyc_n(2);
    chk(slaveEn, 16'h0001);
    runCmd <= 1'b1;
    cyc_n(1);
    runCmd <= 1'b0;
    cyc_n(2);
    chk(consoleMode, 16'h0001);
    rx(1, 8'h33);
    cyc_n(1);
    chk(swSeen, 16'h0033);
    swTxValid[0] <= 1'b1;
    swTxData[0] <= 8'h5A;
    repeat (30) begin
      cyc_n(1);
      if (swTxTaken[0]) break;
    end
    swTxValid[0] <= 1'b0;
    repeat (60) begin
      if (got[0]) break;
      cyc_n(1);
    end
    chk(lastCh[0], 16'h005A);
    rx(0, CH_AT);
    rx(0, CH_AT);
    rx(0, CH_A);
    cyc_n(2);
    chk(attnSeen, 16'h0001);
    rx(0, CH_AT);
    rx(0, CH_AT);
    rx(0, CH_P);
    cyc_n(3);
    chk({consoleMode, refCnt[3:0]}, 16'h0001);
    cpuRun <= 1'b1;
    cyc_n(3);
    chk(consoleMode, 16'h0001);
    cpuRun <= 1'b0;
    cyc_n(3);
    chk({consoleMode, refCnt[3:0]}, 16'h0002);
    resetn <= 1'b0;
    variantStrap <= 1'b1;
    cyc_n(5);
    resetn <= 1'b1;
    cyc_n(3);
    chk({panelAddr, rtomAddr}, 16'h7273);
    cls(4'h7, 1'b1, 4'hF);
    cls(4'hB, 1'b1, 4'h3);
    cls(4'h6, 1'b1, 4'hE);
    cls(4'hF, 1'b0, 4'h0);
    boot("\rIPL\r", 5, 0, 16'h0000);
    complete_run();
  end
endmodule : testbench
